// *** hw/wiper_host.sv ***
// Host controller driving the select, step and direction pins of the pot
`timescale 1ns/1ns
// Overview of operation
// - Host keeps step low when leaving unsaved
// - Host holds select high through power-up
// - Select stays high during power-up recall
// - Direction stays fixed within one selection
module wiper_host
    import wiper_host_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_up,
    input wire logic [steps_w-1:0] cmd_steps,
    input wire logic cmd_save,
    output logic busy,
    output logic done,
    // Device pins
    output logic select_n,
    output logic step_n,
    output logic dir_up
);
    // ********************************************************
    // State
    // ********************************************************
    host_state_s r;
    host_state_s next_r;

    // ********************************************************
    // Helpers
    // ********************************************************
    // True once a phase has lasted n cycles
    function automatic logic expired(input logic [cnt_w-1:0] c,
                                     input int unsigned n);
        return c >= cnt_w'(n - 1);
    endfunction : expired

    // Longer of select and direction setup before a strobe
    function automatic int unsigned setup_wait();
        return (sel_setup_cyc > dir_setup_cyc) ? sel_setup_cyc :
            dir_setup_cyc;
    endfunction : setup_wait

    // Neither a move nor a store: pins stay deselected
    function automatic logic quiet_cmd(input logic [steps_w-1:0] steps,
                                       input logic save);
        return (steps == 5'h00) && !save;
    endfunction : quiet_cmd

    // Final strobe of an unsaved command stays low into deselect
    function automatic logic hold_low(input logic [steps_w:0] left,
                                      input logic save);
        return (left == 6'h01) && !save;
    endfunction : hold_low

    // Wait after select rises: store busy time or short deselect
    function automatic int unsigned desel_wait(input logic save);
        return save ? store_cyc : nostore_cyc;
    endfunction : desel_wait

    // Deselected, strobe high, counters cleared
    function automatic host_state_s reset_state();
        host_state_s s;
        s.state = st_idle;
        s.cnt = cnt_reset;
        s.left = steps_reset;
        s.up = 1'b0;
        s.save = 1'b0;
        s.pins.select_n = 1'b1;
        s.pins.step_n = 1'b1;
        s.pins.dir_up = 1'b0;
        return s;
    endfunction : reset_state

    // ********************************************************
    // Phase timers
    // ********************************************************
    // Each phase ends once its cycle count is reached
    logic setup_over;
    logic low_over;
    logic high_over;
    logic release_over;
    logic desel_over;
    logic steps_spent;

    assign setup_over = expired(r.cnt, setup_wait());
    assign low_over = expired(r.cnt, step_low_cyc);
    assign high_over = expired(r.cnt, step_high_cyc);
    assign release_over = expired(r.cnt, step_desel_cyc);
    assign desel_over = expired(r.cnt, desel_wait(r.save));
    assign steps_spent = (r.left == steps_reset);

    // ********************************************************
    // Sequencer
    // ********************************************************
    // One phase per state; the shared counter times each phase
    always_comb begin
        next_r = r;
        next_r.cnt = r.cnt + 20'h00001;
        case (r.state)
            // Waiting for a command with the device deselected
            st_idle: begin
                next_r.cnt = cnt_reset;
                // Select high while idle, also through power-up
                next_r.pins.select_n = 1'b1;
                next_r.pins.step_n = 1'b1;
                if (cmd_valid) begin
                    next_r.up = cmd_up;
                    next_r.save = cmd_save;
                    next_r.left = {1'b0, cmd_steps};
                    // New direction per command, set with select
                    next_r.pins.dir_up = cmd_up;
                    // Quiet command never selects, so cannot store
                    next_r.pins.select_n =
                        quiet_cmd(cmd_steps, cmd_save);
                    next_r.state = st_setup;
                end
            end
            // Select and direction settle before the first strobe
            st_setup: begin
                if (setup_over) begin
                    next_r.cnt = cnt_reset;
                    if (steps_spent) begin
                        next_r.state = st_release;
                    end else begin
                        // Falling edge moves wiper one tap
                        next_r.pins.step_n = 1'b0;
                        next_r.state = st_low;
                    end
                end
            end
            // Strobe low; the device has already moved
            st_low: begin
                if (low_over) begin
                    next_r.cnt = cnt_reset;
                    next_r.left = r.left - 6'h01;
                    if (hold_low(r.left, r.save)) begin
                        // No extra edge before unsaved leave
                        next_r.state = st_release;
                    end else begin
                        next_r.pins.step_n = 1'b1;
                        next_r.state = st_high;
                    end
                end
            end
            // Strobe high between moves
            st_high: begin
                if (high_over) begin
                    next_r.cnt = cnt_reset;
                    if (steps_spent) begin
                        next_r.state = st_release;
                    end else begin
                        next_r.pins.step_n = 1'b0;
                        next_r.state = st_low;
                    end
                end
            end
            // Strobe settles before select rises
            st_release: begin
                if (release_over) begin
                    next_r.cnt = cnt_reset;
                    // Select rises; step high stores
                    next_r.pins.select_n = 1'b1;
                    next_r.state = st_desel;
                end
            end
            // Deselected; a store keeps the device busy
            st_desel: begin
                // Store busy time, device standby after
                if (desel_over) begin
                    next_r.cnt = cnt_reset;
                    next_r.pins.step_n = 1'b1;
                    next_r.state = st_done;
                end
            end
            // One-cycle completion pulse
            st_done: begin
                next_r.state = st_idle;
            end
            // Unused codes fall back to idle
            default: begin
                next_r.state = st_idle;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        // Reset leaves the pins deselected, strobe high
        if (rst) begin
            r <= reset_state();
        end else begin
            r <= next_r;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    // Handshake from the state code
    assign cmd_ready = (r.state == st_idle);
    assign busy = (r.state != st_idle);
    assign done = (r.state == st_done);
    // Pins straight from flip-flops
    assign select_n = r.pins.select_n;
    assign step_n = r.pins.step_n;
    assign dir_up = r.pins.dir_up;
endmodule : wiper_host

// *** hw/wiper_host_pkg.sv ***
// Package of constants and types for the wiper controller host
package wiper_host_pkg;
    // ********************************************************
    // Timing figures, in nanoseconds, and derived cycle counts
    // ********************************************************
    localparam int unsigned clk_period_ns = 50;
    localparam int unsigned t_sel_setup_ns = 100;
    localparam int unsigned t_dir_setup_ns = 100;
    localparam int unsigned t_step_low_ns = 1000;
    localparam int unsigned t_step_high_ns = 1000;
    localparam int unsigned t_step_to_desel_ns = 1000;
    localparam int unsigned t_desel_nostore_ns = 250;
    localparam int unsigned t_desel_store_ns = 10000000;
    localparam int unsigned t_min_cycles = 1;

    // Least times round up to whole cycles
    function automatic int unsigned min_cycles(input int unsigned ns);
        int unsigned c;
        c = (ns + clk_period_ns - 1) / clk_period_ns;
        return (c < t_min_cycles) ? t_min_cycles : c;
    endfunction : min_cycles

    localparam int unsigned sel_setup_cyc = min_cycles(t_sel_setup_ns);
    localparam int unsigned dir_setup_cyc = min_cycles(t_dir_setup_ns);
    localparam int unsigned step_low_cyc = min_cycles(t_step_low_ns);
    localparam int unsigned step_high_cyc = min_cycles(t_step_high_ns);
    localparam int unsigned step_desel_cyc = min_cycles(t_step_to_desel_ns);
    localparam int unsigned nostore_cyc = min_cycles(t_desel_nostore_ns);
    localparam int unsigned store_cyc = min_cycles(t_desel_store_ns);

    localparam int cnt_w = 20;
    localparam int steps_w = 5;
    localparam logic [cnt_w-1:0] cnt_reset = 20'h00000;
    localparam logic [steps_w:0] steps_reset = 6'h00;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [6:0] {
        st_idle = 7'h01,
        st_setup = 7'h02,
        st_low = 7'h04,
        st_high = 7'h08,
        st_release = 7'h10,
        st_desel = 7'h20,
        st_done = 7'h40
    } state_e;

    // Pins toward the potentiometer
    typedef struct packed {
        logic select_n;
        logic step_n;
        logic dir_up;
    } pins_s;

    typedef struct packed {
        state_e state;
        logic [cnt_w-1:0] cnt;
        logic [steps_w:0] left;
        logic up;
        logic save;
        pins_s pins;
    } host_state_s;
endpackage : wiper_host_pkg

// *** test/tb.sv ***
// Self-checking bench for the wiper host
`timescale 1ns/1ns
module tb;
    import wiper_host_pkg::*;
    logic mclk = 0, rst = 1, cmd_valid = 0, cmd_up = 0, cmd_save = 0;
    logic [4:0] cmd_steps = 5'h00, wiper, stored, exp;
    logic [31:0] taps;
    logic cmd_ready, busy, done, select_n, step_n, dir_up;
    int miscompares = 0, tests_run = 0, cycles = 0, seed = 18739, k;
    always #25 mclk = ~mclk;
    wiper_host u_dut (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_up(cmd_up), .cmd_steps(cmd_steps),
        .cmd_save(cmd_save), .busy(busy), .done(done),
        .select_n(select_n), .step_n(step_n), .dir_up(dir_up));
    wiper_pot u_pot (.mclk(mclk), .rst(rst), .select_n(select_n),
        .step_n(step_n), .dir_up(dir_up), .wiper(wiper), .stored(stored),
        .taps(taps));
    function automatic logic [4:0] moved(logic [4:0] w, logic up, int n);
        for (int i = 0; i < n; i++) begin
            if (up && w != 5'h1f) w = w + 5'h01;
            if (!up && w != 5'h00) w = w - 5'h01;
        end
        return w;
    endfunction : moved
    task automatic check(string name, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", name, e, g);
        end
    endtask : check
    task automatic run(logic up, logic [4:0] n);
        int i;
        cmd_up <= up;
        cmd_steps <= n;
        cmd_valid <= 1'b1;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        for (i = 0; i < 3000 && done !== 1'b1; i++) @(negedge mclk);
        check("done", 32'h1, done);
        @(posedge mclk);
        exp = moved(exp, up, n);
        check("wiper", exp, wiper);
        check("taps", 32'h1 << exp, taps);
    endtask : run
    task automatic summarize;
        if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        exp = stored;
        check("recall", 32'h10, wiper);
        run(1, 31); run(1, 5); run(0, 31); run(0, 1); run(1, 0);
        for (k = 0; k < 14; k++) run($random(seed), $random(seed));
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        exp = stored;
        check("power", 32'h10, wiper);
        run(1, 3);
        cmd_save <= 1'b1;
        cmd_valid <= 1'b1;
        cmd_steps <= 5'h02;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        @(negedge mclk);
        for (k = 0; k < 3000 && select_n !== 1'b1; k++) @(negedge mclk);
        check("select", 32'h1, select_n);
        repeat (50) @(negedge mclk);
        check("stored", moved(exp, 1, 2), stored);
        summarize();
    end
endmodule : tb

// *** test/wiper_host_properties.sv ***
// Port assertions for the wiper host
`timescale 1ns/1ns
module wiper_host_properties (
    input wire logic mclk, rst, cmd_valid, cmd_ready, cmd_up,
    input wire logic busy, done, select_n, step_n, dir_up, cmd_save,
    input wire logic [4:0] cmd_steps
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_take; cmd_valid && cmd_ready |=> busy && !cmd_ready
        && dir_up == $past(cmd_up) && select_n == ($past(cmd_steps)
        == 5'h00 && !$past(cmd_save)); endproperty
    a_take: assert property (p_take) else $error("take");
    property p_fall_sel; $fell(step_n) |-> !select_n; endproperty
    a_fall_sel: assert property (p_fall_sel) else $error("fall");
    property p_dir; $fell(step_n) |-> $stable(dir_up); endproperty
    a_dir: assert property (p_dir) else $error("dir");
    property p_low; $fell(step_n) |-> !step_n [*8]; endproperty
    a_low: assert property (p_low) else $error("low");
    property p_nostore; $rose(select_n) && !step_n |-> !step_n [*4];
    endproperty
    a_nostore: assert property (p_nostore) else $error("nostore");
    property p_idle; !busy |-> select_n && step_n && cmd_ready; endproperty
    a_idle: assert property (p_idle) else $error("idle");
    property p_done; done |=> !done && !busy; endproperty
    a_done: assert property (p_done) else $error("done");
    property p_ready; cmd_ready |-> !busy; endproperty
    a_ready: assert property (p_ready) else $error("ready");
endmodule : wiper_host_properties
bind wiper_host wiper_host_properties u_props (.mclk(mclk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_up(cmd_up),
    .busy(busy), .done(done), .select_n(select_n), .step_n(step_n),
    .dir_up(dir_up), .cmd_save(cmd_save), .cmd_steps(cmd_steps));

// *** test/wiper_pot.sv ***
// Behavioural model of the potentiometer control logic
`timescale 1ns/1ns
module wiper_pot #(parameter logic [4:0] nv_init = 5'h10) (
    input wire logic mclk, rst, select_n, step_n, dir_up,
    output logic [4:0] wiper, stored,
    output logic [31:0] taps
);
    logic sel_q, step_q;
    initial stored = nv_init;
    always @(posedge mclk) begin
        if (rst) begin
            wiper <= stored;
        end else if (!select_n && step_q && !step_n) begin
            if (dir_up && wiper != 5'h1f) wiper <= wiper + 5'h01;
            else if (!dir_up && wiper != 5'h00) wiper <= wiper - 5'h01;
        end else if (!sel_q && select_n && step_n) begin
            stored <= wiper;
        end
        sel_q <= select_n;
        step_q <= step_n;
    end
    assign taps = 32'h1 << wiper;
endmodule : wiper_pot
